// ==== core/acp_pkg.sv ====
`default_nettype none
package acp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CALIB   = 6'h07;
    localparam logic [5:0] IDX_AUDIO   = 6'h08;
    localparam logic [5:0] IDX_CTRL    = 6'h0A;
    localparam logic [5:0] IDX_TRICKLE = 6'h0B;
    localparam logic [5:0] IDX_STATUS  = 6'h0C;

    // Audio register fields
    localparam int AUD_GAIN_LSB = 0;
    localparam int AUD_MUTE     = 4;
    localparam int AUD_TONE_EN  = 5;
    localparam int AUD_TONE_SEL = 6;
    // Calibration register fields
    localparam int CAL_VAL_LSB  = 0;
    localparam int CAL_SIGN     = 5;
    // Control register fields
    localparam int CTL_OSC_STOP = 0;
    localparam int CTL_HALT     = 1;
    localparam int CTL_OUT      = 2;
    localparam int CTL_FT       = 3;
    localparam int CTL_OF       = 4;
    localparam int CTL_OSC_FAIL_IRQ_ENABLE     = 5;
    // Trickle register fields
    localparam int TRK_EN_LSB   = 0;
    localparam int TRK_SW_A     = 4;
    localparam int TRK_SW_B     = 5;

    // Power-up values
    localparam logic [3:0] GAIN_FIRST    = 4'h0;
    localparam logic [3:0] TRICKLE_OPEN  = 4'hA;
    localparam logic [3:0] TRICKLE_CLOSE = 4'h5;
    localparam logic [4:0] CAL_FIRST     = 5'h00;

    // Gain law: code 0 is -33 dB, 3 dB a step
    localparam int GAIN_BASE_DB = -33;
    localparam int GAIN_STEP_DB = 3;

    // Tone timing
    localparam int CLK_HZ         = 100_000_000;
    localparam int TONE_HI_HZ     = 512;
    localparam int TONE_LO_HZ     = 256;
    localparam int TONE_HALF_CYC  = CLK_HZ / (2 * TONE_HI_HZ);
endpackage
`default_nettype wire

// ==== core/acp_clkdiv.sv ====
`timescale 1ns/1ps
`default_nettype none
// Free-running divider giving a one-cycle enable every DIV clocks
module acp_clkdiv #(
    parameter int DIV = 4
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Enable out
    output logic      tick
);
    logic [31:0] cnt_q;

    // Count up and pulse on wrap
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b0;
        end
        else if (cnt_q == 32'(DIV - 1))
        begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== core/acp_gain_map.sv ====
`timescale 1ns/1ps
`default_nettype none
// Maps the 4-bit volume code to signed gain in dB
module acp_gain_map (
    // Code in
    input  wire logic [3:0] code,
    // Gain out, two's complement dB
    output logic      [6:0] gain_db
);
    logic signed [7:0] lin;

    // Linear law, no table needed
    always_comb
    begin
        lin     = 8'(acp_pkg::GAIN_BASE_DB)
                + 8'(acp_pkg::GAIN_STEP_DB) * 8'(code);
        gain_db = lin[6:0];
    end
endmodule
`default_nettype wire

// ==== core/acp_audio_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
module acp_audio_ctl #(
    parameter int TONE_HALF_CYC = acp_pkg::TONE_HALF_CYC
) (
    // Clock and reset; reset is the first application of power
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Power events
    input  wire logic       power_up,
    input  wire logic       backup_lost,
    input  wire logic       osc_stopped,
    // Avalon-MM slave
    input  wire logic [7:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0] avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic            avs_waitrequest,
    // Audio path control
    output logic      [6:0] gain_db_q,
    output logic            audio_on_q,
    output logic            tone_sel_path_q,
    output logic            tone_wave_q,
    // Clock core control
    output logic            osc_stop_bit_q,
    output logic            halt_update_bit_q,
    output logic            trickle_closed_q,
    // Open-drain pin, enable low while driving
    output logic            mfo_pin_o_q,
    output logic            mfo_pin_oe_n_q
);
    // Register state
    logic [3:0] gain_q;
    logic       mute_q, tone_en_q, tone_sel_q;
    logic [4:0] cal_val_q;
    logic       cal_sign_q;
    logic       out_bit_q, ft_q, of_q, osc_fail_irq_enable_q;
    logic [3:0] trk_en_q;
    logic       trk_a_q, trk_b_q;
    logic       retained_q;
    logic [5:0] idx;
    logic       wr_go, lane0;
    logic [7:0] wd;
    logic [6:0] gain_db_d;
    logic       half_tick, tone_hi_q, tone_lo_q;

    assign idx   = avs_address[7:2];
    assign wd    = avs_writedata[7:0];
    assign lane0 = avs_byteenable[0];
    // Write lands on the edge where the master sees waitrequest low
    assign wr_go = avs_write && !avs_waitrequest && lane0;

    // One wait cycle, then an answer cycle; never two answers in a row
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end

    // Read data, captured with the answer; unmapped reads give zero
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && avs_waitrequest)
        begin
            case (idx)
                acp_pkg::IDX_AUDIO:   avs_readdata <= {25'h0, tone_sel_q, tone_en_q,
                                                       mute_q, gain_q};
                acp_pkg::IDX_CALIB:   avs_readdata <= {26'h0, cal_sign_q, cal_val_q};
                acp_pkg::IDX_CTRL:    avs_readdata <= {26'h0, osc_fail_irq_enable_q, of_q, ft_q, out_bit_q,
                                                       halt_update_bit_q, osc_stop_bit_q};
                acp_pkg::IDX_TRICKLE: avs_readdata <= {26'h0, trk_b_q, trk_a_q, trk_en_q};
                acp_pkg::IDX_STATUS:  avs_readdata <= {30'h0, tone_wave_q, retained_q};
                default:              avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Retained indicator: set once power has been seen, lost with backup
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            retained_q <= 1'b1; // Reset is the first power-up, so backup now holds state
        else if (backup_lost)
            retained_q <= 1'b0;
        else if (power_up)
            retained_q <= 1'b1;
    end

    // Audio register: gain kept or cleared by the default set, mute always set
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gain_q     <= acp_pkg::GAIN_FIRST;
            mute_q     <= 1'b1;
            tone_en_q  <= 1'b0;
            tone_sel_q <= 1'b1;
        end
        else if (power_up)
        begin
            if (!retained_q)
            begin
                gain_q     <= acp_pkg::GAIN_FIRST;
                tone_sel_q <= 1'b1;
            end
            mute_q    <= 1'b1;
            tone_en_q <= 1'b0;
        end
        else if (wr_go && idx == acp_pkg::IDX_AUDIO)
        begin
            gain_q     <= wd[acp_pkg::AUD_GAIN_LSB +: 4];
            mute_q     <= wd[acp_pkg::AUD_MUTE];
            tone_en_q  <= wd[acp_pkg::AUD_TONE_EN];
            tone_sel_q <= wd[acp_pkg::AUD_TONE_SEL];
        end
    end

    // Calibration register, untouched by later power-ups
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_val_q  <= acp_pkg::CAL_FIRST;
            cal_sign_q <= 1'b0;
        end
        else if (power_up && !retained_q)
        begin
            cal_val_q  <= acp_pkg::CAL_FIRST;
            cal_sign_q <= 1'b0;
        end
        else if (!power_up && wr_go && idx == acp_pkg::IDX_CALIB)
        begin
            cal_val_q  <= wd[acp_pkg::CAL_VAL_LSB +: 5];
            cal_sign_q <= wd[acp_pkg::CAL_SIGN];
        end
    end

    // Control register; enable-type bits undefined by default are simply cleared
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_stop_bit_q    <= 1'b0;
            halt_update_bit_q <= 1'b1;
            out_bit_q         <= 1'b1;
            ft_q              <= 1'b0;
            osc_fail_irq_enable_q            <= 1'b0;
        end
        else if (power_up)
        begin
            if (!retained_q)
            begin
                osc_stop_bit_q <= 1'b0;
                out_bit_q      <= 1'b1;
                osc_fail_irq_enable_q         <= 1'b0;
            end
            halt_update_bit_q <= 1'b1;
            ft_q              <= 1'b0;
        end
        else if (wr_go && idx == acp_pkg::IDX_CTRL)
        begin
            osc_stop_bit_q    <= wd[acp_pkg::CTL_OSC_STOP];
            halt_update_bit_q <= wd[acp_pkg::CTL_HALT];
            out_bit_q         <= wd[acp_pkg::CTL_OUT];
            ft_q              <= wd[acp_pkg::CTL_FT];
            osc_fail_irq_enable_q            <= wd[acp_pkg::CTL_OSC_FAIL_IRQ_ENABLE];
        end
    end

    // Oscillator fail flag: a stop event wins over a software clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            of_q <= 1'b1;
        else if (osc_stopped || (power_up && !retained_q))
            of_q <= 1'b1;
        else if (!power_up && wr_go && idx == acp_pkg::IDX_CTRL)
            of_q <= wd[acp_pkg::CTL_OF];
    end

    // Trickle charger, forced open on every power-up
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trk_en_q <= acp_pkg::TRICKLE_OPEN;
            trk_a_q  <= 1'b0;
            trk_b_q  <= 1'b0;
        end
        else if (power_up)
        begin
            trk_en_q <= acp_pkg::TRICKLE_OPEN;
            trk_a_q  <= 1'b0;
            trk_b_q  <= 1'b0;
        end
        else if (wr_go && idx == acp_pkg::IDX_TRICKLE)
        begin
            trk_en_q <= wd[acp_pkg::TRK_EN_LSB +: 4];
            trk_a_q  <= wd[acp_pkg::TRK_SW_A];
            trk_b_q  <= wd[acp_pkg::TRK_SW_B];
        end
    end

    // Only the exact key closes the charger path
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            trickle_closed_q <= 1'b0;
        else
            trickle_closed_q <= trk_en_q == acp_pkg::TRICKLE_CLOSE;
    end

    // Half-period ticks of the 512 Hz tone
    acp_clkdiv #(
        .DIV (TONE_HALF_CYC)
    ) u_tone_div (
        .mclk  (mclk),
        .rst_n (rst_n),
        .tick  (half_tick)
    );

    // 512 Hz toggles each tick, 256 Hz on every other one
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tone_hi_q <= 1'b0;
            tone_lo_q <= 1'b0;
        end
        else if (half_tick)
        begin
            tone_hi_q <= !tone_hi_q;
            if (tone_hi_q)
                tone_lo_q <= !tone_lo_q;
        end
    end

    acp_gain_map u_gain_map (
        .code    (gain_q),
        .gain_db (gain_db_d)
    );

    // Audio path outputs; mute clears only audio_on_q, the tone outputs ignore it
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gain_db_q       <= 7'h00;
            audio_on_q      <= 1'b0;
            tone_sel_path_q <= 1'b0;
            tone_wave_q     <= 1'b0;
        end
        else
        begin
            gain_db_q       <= gain_db_d;
            audio_on_q      <= !mute_q;
            tone_sel_path_q <= tone_en_q;
            tone_wave_q     <= tone_en_q && (tone_sel_q ? tone_hi_q : tone_lo_q);
        end
    end

    // Open-drain pin: test tone when enabled, else the discrete bit; 1 releases it
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mfo_pin_o_q    <= 1'b0;
            mfo_pin_oe_n_q <= 1'b1;
        end
        else
        begin
            mfo_pin_o_q    <= 1'b0;
            mfo_pin_oe_n_q <= ft_q ? tone_hi_q : out_bit_q;
        end
    end

    // Checks
    sequence s_first_pu;
        power_up && !retained_q;
    endsequence
    sequence s_later_pu;
        power_up && retained_q && !backup_lost;
    endsequence

    a_first_gain_mute: assert property (@(posedge mclk) disable iff (!rst_n)
        s_first_pu |=> gain_q == 4'h0 && mute_q ##1 !audio_on_q)
        else $error("first power-up left gain or mute wrong");
    a_later_gain_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        s_later_pu |=> gain_q == $past(gain_q) && mute_q)
        else $error("later power-up changed gain or left mute clear");
    a_halt_set_pu: assert property (@(posedge mclk) disable iff (!rst_n)
        power_up |=> halt_update_bit_q && !ft_q)
        else $error("power-up did not set halt or clear test");
    a_osc_stop_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        s_later_pu |=> osc_stop_bit_q == $past(osc_stop_bit_q))
        else $error("later power-up changed oscillator stop");
    a_of_first_set: assert property (@(posedge mclk) disable iff (!rst_n)
        s_first_pu or osc_stopped |=> of_q)
        else $error("oscillator fail flag not set");
    a_trickle_open: assert property (@(posedge mclk) disable iff (!rst_n)
        power_up |=> trk_en_q == 4'hA && !trk_a_q && !trk_b_q ##1 !trickle_closed_q)
        else $error("trickle not opened at power-up");
    a_tone_cleared: assert property (@(posedge mclk) disable iff (!rst_n)
        power_up |=> !tone_en_q ##1 !tone_sel_path_q && !tone_wave_q)
        else $error("tone still enabled after power-up");
    a_calib_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        s_later_pu |=> $stable(cal_val_q) && $stable(cal_sign_q))
        else $error("later power-up altered calibration");
    a_gain_law: assert property (@(posedge mclk) disable iff (!rst_n)
        gain_q == 4'hB && $stable(gain_q) |=> gain_db_q == 7'h00)
        else $error("code 11 is not 0 dB");
    a_mute_silence: assert property (@(posedge mclk) disable iff (!rst_n)
        mute_q |=> !audio_on_q)
        else $error("audio on while muted");
    a_wait_answer: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
endmodule
`default_nettype wire

// ==== tb/acp_audio_ctl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module acp_audio_ctl_tb;
    // Short tone half period keeps the run brief
    localparam int HALF = 4;

    logic        mclk;
    logic        rst_n;
    logic        power_up;
    logic        backup_lost;
    logic        osc_stopped;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [6:0]  gain_db_q;
    logic        audio_on_q;
    logic        tone_sel_path_q;
    logic        tone_wave_q;
    logic        osc_stop_bit_q;
    logic        halt_update_bit_q;
    logic        trickle_closed_q;
    logic        mfo_pin_o_q;
    logic        mfo_pin_oe_n_q;
    logic [7:0]  outs;
    logic [7:0]  rd;
    int          fails;
    int          n_compared;
    int          per;

    acp_audio_ctl #(.TONE_HALF_CYC(HALF)) i_acp_audio_ctl (
        .mclk              (mclk),
        .rst_n             (rst_n),
        .power_up          (power_up),
        .backup_lost       (backup_lost),
        .osc_stopped       (osc_stopped),
        .avs_address       (avs_address),
        .avs_read          (avs_read),
        .avs_write         (avs_write),
        .avs_writedata     (avs_writedata),
        .avs_byteenable    (avs_byteenable),
        .avs_readdata      (avs_readdata),
        .avs_waitrequest   (avs_waitrequest),
        .gain_db_q         (gain_db_q),
        .audio_on_q        (audio_on_q),
        .tone_sel_path_q   (tone_sel_path_q),
        .tone_wave_q       (tone_wave_q),
        .osc_stop_bit_q    (osc_stop_bit_q),
        .halt_update_bit_q (halt_update_bit_q),
        .trickle_closed_q  (trickle_closed_q),
        .mfo_pin_o_q       (mfo_pin_o_q),
        .mfo_pin_oe_n_q    (mfo_pin_oe_n_q)
    );

    // Status levels packed so one compare covers several outputs
    assign outs = {mfo_pin_o_q, trickle_closed_q, tone_sel_path_q, tone_wave_q,
                   audio_on_q, halt_update_bit_q, osc_stop_bit_q, mfo_pin_oe_n_q};

    // Free-running 100 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Compare seen against expected
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One bus cycle; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge mclk);
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50)
        begin
            fails++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hF);
    endtask

    // Read and compare the masked field
    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] mask, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 4'hF);
        check(rd & mask, exp);
    endtask

    // Lets derived outputs follow a register change
    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask

    // One-cycle power event: {power_up, backup_lost, osc_stopped}
    task automatic pulse(input logic [2:0] v);
        @(posedge mclk);
        {power_up, backup_lost, osc_stopped} <= v;
        @(posedge mclk);
        {power_up, backup_lost, osc_stopped} <= 3'h0;
        settle();
    endtask

    // Cycles between two rising edges of the tone; bounded search
    task automatic tone_period(output int cyc);
        int n;
        n = 0;
        cyc = 0;
        while (tone_wave_q !== 1'b0 && n < 400)
        begin
            @(posedge mclk);
            n++;
        end
        while (tone_wave_q !== 1'b1 && n < 400)
        begin
            @(posedge mclk);
            n++;
        end
        // Count from this rising edge to the next one
        while (tone_wave_q !== 1'b0 && n < 400)
        begin
            @(posedge mclk);
            n++;
            cyc++;
        end
        while (tone_wave_q !== 1'b1 && n < 400)
        begin
            @(posedge mclk);
            n++;
            cyc++;
        end
        if (n >= 400)
        begin
            fails++;
            tally_and_finish();
        end
    endtask

    initial
    begin
        rst_n          = 1'b0;
        power_up       = 1'b0;
        backup_lost    = 1'b0;
        osc_stopped    = 1'b0;
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'h0;
        fails          = 0;
        n_compared     = 0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        // First application of power
        check({1'b0, gain_db_q}, 8'h5F);
        check(outs, 8'h05);
        rd_chk(acp_pkg::IDX_AUDIO, 8'h7F, 8'h50);
        rd_chk(acp_pkg::IDX_CTRL, 8'h1F, 8'h16);
        rd_chk(acp_pkg::IDX_TRICKLE, 8'h3F, 8'h0A);
        rd_chk(acp_pkg::IDX_CALIB, 8'h3F, 8'h00);
        rd_chk(6'h3F, 8'hFF, 8'h00);
        // Every volume code, unmuted
        for (int c = 0; c < 16; c++)
        begin
            wr(acp_pkg::IDX_AUDIO, 8'(c));
            settle();
            check({1'b0, gain_db_q}, {1'b0, 7'(acp_pkg::GAIN_BASE_DB + acp_pkg::GAIN_STEP_DB * c)});
            check(outs & 8'h08, 8'h08);
            rd_chk(acp_pkg::IDX_AUDIO, 8'h1F, 8'(c));
        end
        // Mute at the loudest code still silences
        wr(acp_pkg::IDX_AUDIO, 8'h1F);
        settle();
        check(outs & 8'h08, 8'h00);
        // Write with the low byte lane off must not land
        bus(1'b1, acp_pkg::IDX_AUDIO, 8'h00, 4'h0);
        rd_chk(acp_pkg::IDX_AUDIO, 8'h1F, 8'h1F);
        // Both tone rates replace the amplifier signal
        for (int s = 0; s < 2; s++)
        begin
            wr(acp_pkg::IDX_AUDIO, {1'b0, s[0], 6'h20});
            settle();
            check(outs & 8'h20, 8'h20);
            tone_period(per);
            check(per[7:0], s[0] ? 8'(2 * HALF) : 8'(4 * HALF));
        end
        // Software values ahead of a later power-up
        wr(acp_pkg::IDX_CTRL, 8'h01);
        settle();
        check(outs & 8'h07, 8'h02);
        wr(acp_pkg::IDX_CTRL, 8'h09);
        wr(acp_pkg::IDX_TRICKLE, 8'h35);
        settle();
        check(outs & 8'h40, 8'h40);
        // Frequency test on: the pin follows the 512 Hz tone, one flip per half period
        rd = {7'h00, mfo_pin_oe_n_q};
        repeat (HALF) @(posedge mclk);
        check({7'h00, mfo_pin_oe_n_q}, {7'h00, ~rd[0]});
        check(outs & 8'h80, 8'h00);
        wr(acp_pkg::IDX_CALIB, 8'h2B);
        wr(acp_pkg::IDX_AUDIO, 8'h27);
        pulse(3'b100);
        rd_chk(acp_pkg::IDX_AUDIO, 8'h7F, 8'h17);
        rd_chk(acp_pkg::IDX_CTRL, 8'h1F, 8'h03);
        check(outs & 8'h6F, 8'h06);
        rd_chk(acp_pkg::IDX_TRICKLE, 8'h3F, 8'h0A);
        rd_chk(acp_pkg::IDX_CALIB, 8'h3F, 8'h2B);
        rd_chk(acp_pkg::IDX_STATUS, 8'h01, 8'h01);
        pulse(3'b001);
        rd_chk(acp_pkg::IDX_CTRL, 8'h10, 8'h10);
        // Backup gone: next power-up is a first one again
        pulse(3'b010);
        rd_chk(acp_pkg::IDX_STATUS, 8'h01, 8'h00);
        pulse(3'b100);
        rd_chk(acp_pkg::IDX_AUDIO, 8'h7F, 8'h50);
        rd_chk(acp_pkg::IDX_CTRL, 8'h1F, 8'h16);
        rd_chk(acp_pkg::IDX_CALIB, 8'h3F, 8'h00);
        check(outs & 8'h07, 8'h05);
        tally_and_finish();
    end
endmodule
`default_nettype wire
